//--- rtl/crs_register_set.sv
// Function
// - 32 general registers, 32-bit system registers
// - register zero reads zero, ignores writes
// - short load/store base is register 30
// - program counter keeps 26 bits only
// - program counter bit 0 always zero
// - system registers selected by number
// - cause and debug indicator are read-only
// - return ignores saved address bit 0
// - exception/interrupt saves pc, status to irq pair
// - nmi saves pc, status to nmi pair
// - saved address is the following instruction
// - single save pair each, overwritten per event
// - saved address/status upper bits read zero
// - cause register loaded on every event
// - status write immediate, block flag early
// - status bits 31 to 8 read zero
// - nmi sets nmi flag, blocks nesting
// - exception sets exception flag, irqs blocked
// - block flag gates maskable interrupts
// - saturation flag sticky until status write or return
// - sign and zero flags follow result
`timescale 1ns/1ns
`default_nettype none
module crs_register_set (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [crs_pkg::GPR_AW-1:0] gpr_rd_a_addr,
  output logic [crs_pkg::XLEN-1:0] gpr_rd_a_data,
  input wire logic [crs_pkg::GPR_AW-1:0] gpr_rd_b_addr,
  output logic [crs_pkg::XLEN-1:0] gpr_rd_b_data,
  input wire logic gpr_wr_en,
  input wire logic [crs_pkg::GPR_AW-1:0] gpr_wr_addr,
  input wire logic [crs_pkg::XLEN-1:0] gpr_wr_data,
  output logic [crs_pkg::XLEN-1:0] short_mem_base,
  input wire logic pc_branch,
  input wire logic [crs_pkg::XLEN-1:0] pc_branch_target,
  input wire logic pc_advance,
  input wire logic [crs_pkg::STEP_W-1:0] instr_len,
  output logic [crs_pkg::XLEN-1:0] pc,
  input wire logic sysreg_write_instr,
  input wire logic sysreg_read_instr,
  input wire logic [crs_pkg::SR_AW-1:0] sysreg_num,
  input wire logic [crs_pkg::XLEN-1:0] sysreg_wdata,
  output logic [crs_pkg::XLEN-1:0] sysreg_rdata,
  input wire logic flags_we,
  input wire logic [crs_pkg::XLEN-1:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  input wire logic sat_event,
  input wire logic ev_sw_exception,
  input wire logic ev_irq,
  input wire logic ev_nmi,
  input wire logic ev_trap,
  input wire logic table_call_instr,
  input wire logic [crs_pkg::XLEN-1:0] ev_cause,
  input wire logic [crs_pkg::XLEN-1:0] ev_vector,
  input wire logic interrupt_return_instr,
  input wire logic table_call_return,
  input wire logic trap_return,
  output logic irq_accept_ok,
  output logic nmi_accept_ok,
  output logic [crs_pkg::ST_W-1:0] cpu_status_word,
  output logic debug_mode
);
  import crs_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0] irq_return_addr;
    logic [ST_W-1:0] irq_saved_status;
    logic [PC_W-1:0] nmi_return_addr;
    logic [ST_W-1:0] nmi_saved_status;
    logic [XLEN-1:0] event_cause;
    logic [ST_W-1:0] status;
    logic [PC_W-1:0] table_call_return_addr;
    logic [ST_W-1:0] table_call_saved_status;
    logic [PC_W-1:0] trap_return_addr;
    logic [ST_W-1:0] trap_saved_status;
    logic [PC_W-1:0] table_call_base;
    logic dbg;
    logic [XLEN-1:0] rdata;
  } crs_state_s;

  crs_state_s s_q, s_d;
  logic [XLEN-1:0] pc_now;
  logic [XLEN-1:0] ret_addr;
  logic pc_load;
  logic [XLEN-1:0] pc_target;
  logic any_event;
  logic sr_wr_ok;
  logic status_wr;
  logic block_now;

  function automatic logic [XLEN-1:0] zx_pc(input logic [PC_W-1:0] v);
    zx_pc = {{(XLEN-PC_W){1'b0}}, v};
  endfunction

  function automatic logic [XLEN-1:0] zx_st(input logic [ST_W-1:0] v);
    zx_st = {{(XLEN-ST_W){1'b0}}, v};
  endfunction

  // unlisted numbers answer zero; software must not rely on it
  function automatic logic [XLEN-1:0] sr_read(input crs_state_s s,
                                              input logic [SR_AW-1:0] n);
    unique case (n)
      SR_IRQ_RA: sr_read = zx_pc(s.irq_return_addr);
      SR_IRQ_ST: sr_read = zx_st(s.irq_saved_status);
      SR_NMI_RA: sr_read = zx_pc(s.nmi_return_addr);
      SR_NMI_ST: sr_read = zx_st(s.nmi_saved_status);
      SR_CAUSE: sr_read = s.event_cause;
      SR_STATUS: sr_read = zx_st(s.status);
      SR_TC_RA: sr_read = zx_pc(s.table_call_return_addr);
      SR_TC_ST: sr_read = zx_st(s.table_call_saved_status);
      SR_TR_RA: sr_read = zx_pc(s.trap_return_addr);
      SR_TR_ST: sr_read = zx_st(s.trap_saved_status);
      SR_TC_BASE: sr_read = zx_pc(s.table_call_base);
      SR_DBG_IND: sr_read = {{(XLEN-1){1'b0}}, s.dbg};
      default: sr_read = '0;
    endcase
  endfunction

  function automatic logic [ST_W-1:0] entry_status(input logic [ST_W-1:0] st,
                                                   input logic nmi,
                                                   input logic exc);
    entry_status = st;
    entry_status[ST_IRQ_BLOCK] = 1'b1;
    if (nmi) begin
      entry_status[ST_NMI_ACTIVE] = 1'b1;
    end
    if (exc) begin
      entry_status[ST_EXC_ACTIVE] = 1'b1;
    end
  endfunction

  // registers 1 to 31, 32 bits each, live in the array below; register zero is not stored
  crs_gpr_file #(
    .N(GPR_N)
  ) u_gpr (
    .clk(clk),
    .sys_rst(sys_rst),
    .rd_a_addr(gpr_rd_a_addr),
    .rd_a_data(gpr_rd_a_data),
    .rd_b_addr(gpr_rd_b_addr),
    .rd_b_data(gpr_rd_b_data),
    .wr_en(gpr_wr_en),
    .wr_addr(gpr_wr_addr),
    .wr_data(gpr_wr_data),
    .elem_ptr(short_mem_base)
  );

  crs_pc u_pc (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(pc_load),
    .target(pc_target),
    .advance(pc_advance),
    .step(instr_len),
    .pc(pc_now)
  );

  // address of the instruction after the one in flight
  assign ret_addr = (pc_now + zx_pc(PC_W'(instr_len))) & RA_MASK;

  assign any_event = ev_nmi || ev_irq || ev_sw_exception || ev_trap;
  assign status_wr = sysreg_write_instr && sysreg_num == SR_STATUS;
  // block takes effect while the write itself executes
  assign block_now = s_q.status[ST_IRQ_BLOCK] ||
                     (status_wr && sysreg_wdata[ST_IRQ_BLOCK]);
  assign irq_accept_ok = !block_now &&
                         !s_q.status[ST_NMI_ACTIVE];
  assign nmi_accept_ok = !s_q.status[ST_NMI_ACTIVE];
  // an event in the same cycle overrides a system register write
  assign sr_wr_ok = sysreg_write_instr && !any_event;

  always_comb begin
    pc_load = 1'b0;
    pc_target = pc_branch_target;
    if (any_event || table_call_instr) begin
      pc_load = 1'b1;
      pc_target = ev_vector;
    end else if (interrupt_return_instr) begin
      pc_load = 1'b1;
      pc_target = s_q.status[ST_NMI_ACTIVE] ?
                  zx_pc(s_q.nmi_return_addr) :
                  zx_pc(s_q.irq_return_addr);
    end else if (table_call_return) begin
      pc_load = 1'b1;
      pc_target = zx_pc(s_q.table_call_return_addr);
    end else if (trap_return) begin
      pc_load = 1'b1;
      pc_target = zx_pc(s_q.trap_return_addr);
    end else if (pc_branch) begin
      pc_load = 1'b1;
    end
  end

  always_comb begin
    s_d = s_q;
    if (sysreg_read_instr) begin
      s_d.rdata = sr_read(s_q, sysreg_num);
    end
    if (flags_we) begin
      s_d.status[ST_Z] = (alu_result == '0);
      s_d.status[ST_S] = alu_result[XLEN-1];
      s_d.status[ST_OV] = alu_overflow;
      s_d.status[ST_CY] = alu_carry;
    end
    if (sr_wr_ok) begin
      unique case (sysreg_num)
        SR_IRQ_RA: s_d.irq_return_addr = sysreg_wdata[PC_W-1:0];
        SR_IRQ_ST: s_d.irq_saved_status = sysreg_wdata[ST_W-1:0];
        SR_NMI_RA: s_d.nmi_return_addr = sysreg_wdata[PC_W-1:0];
        SR_NMI_ST: s_d.nmi_saved_status = sysreg_wdata[ST_W-1:0];
        SR_STATUS: s_d.status = sysreg_wdata[ST_W-1:0];
        SR_TC_RA: s_d.table_call_return_addr = sysreg_wdata[PC_W-1:0];
        SR_TC_ST: s_d.table_call_saved_status = sysreg_wdata[ST_W-1:0];
        SR_TR_RA: s_d.trap_return_addr = sysreg_wdata[PC_W-1:0];
        SR_TR_ST: s_d.trap_saved_status = sysreg_wdata[ST_W-1:0];
        SR_TC_BASE: s_d.table_call_base = sysreg_wdata[PC_W-1:0] &
                                          PC_MASK[PC_W-1:0];
        default: begin
        end
      endcase
    end
    // saturation set wins over any clearing write
    if (sat_event) begin
      s_d.status[ST_SAT] = 1'b1;
    end
    if (ev_nmi) begin
      s_d.nmi_return_addr = ret_addr[PC_W-1:0];
      s_d.nmi_saved_status = s_q.status;
      s_d.event_cause = ev_cause;
      s_d.status = entry_status(s_q.status, 1'b1, 1'b0);
    end else if (ev_irq || ev_sw_exception) begin
      s_d.irq_return_addr = ret_addr[PC_W-1:0];
      s_d.irq_saved_status = s_q.status;
      s_d.event_cause = ev_cause;
      s_d.status = entry_status(s_q.status, 1'b0, ev_sw_exception);
    end else if (ev_trap) begin
      s_d.trap_return_addr = ret_addr[PC_W-1:0];
      s_d.trap_saved_status = s_q.status;
      s_d.event_cause = ev_cause;
      s_d.status = entry_status(s_q.status, 1'b1, 1'b1);
      s_d.dbg = 1'b1;
    end else if (table_call_instr) begin
      s_d.table_call_return_addr = ret_addr[PC_W-1:0];
      s_d.table_call_saved_status = s_q.status;
    end else if (interrupt_return_instr) begin
      s_d.status = s_q.status[ST_NMI_ACTIVE] ? s_q.nmi_saved_status :
                                               s_q.irq_saved_status;
    end else if (table_call_return) begin
      s_d.status = s_q.table_call_saved_status;
    end else if (trap_return) begin
      s_d.status = s_q.trap_saved_status;
      s_d.dbg = 1'b0;
    end
    if (sat_event && !any_event) begin
      s_d.status[ST_SAT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.status <= STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pc = pc_now;
  assign sysreg_rdata = s_q.rdata;
  assign cpu_status_word = s_q.status;
  assign debug_mode = s_q.dbg;
endmodule
`default_nettype wire

//--- rtl/crs_pkg.sv
package crs_pkg;
  localparam int XLEN = 32;
  localparam int PC_W = 26;
  localparam int ST_W = 8;
  localparam int GPR_N = 32;
  localparam int GPR_AW = 5;
  localparam int SR_AW = 5;
  localparam int STEP_W = 3;
  localparam logic [GPR_AW-1:0] GPR_ZERO = 5'h00;
  localparam logic [GPR_AW-1:0] GPR_ELEM_PTR = 5'h1E;
  localparam logic [SR_AW-1:0] SR_IRQ_RA = 5'h00;
  localparam logic [SR_AW-1:0] SR_IRQ_ST = 5'h01;
  localparam logic [SR_AW-1:0] SR_NMI_RA = 5'h02;
  localparam logic [SR_AW-1:0] SR_NMI_ST = 5'h03;
  localparam logic [SR_AW-1:0] SR_CAUSE = 5'h04;
  localparam logic [SR_AW-1:0] SR_STATUS = 5'h05;
  localparam logic [SR_AW-1:0] SR_TC_RA = 5'h10;
  localparam logic [SR_AW-1:0] SR_TC_ST = 5'h11;
  localparam logic [SR_AW-1:0] SR_TR_RA = 5'h12;
  localparam logic [SR_AW-1:0] SR_TR_ST = 5'h13;
  localparam logic [SR_AW-1:0] SR_TC_BASE = 5'h14;
  localparam logic [SR_AW-1:0] SR_DBG_IND = 5'h15;
  localparam int ST_NMI_ACTIVE = 7;
  localparam int ST_EXC_ACTIVE = 6;
  localparam int ST_IRQ_BLOCK = 5;
  localparam int ST_SAT = 4;
  localparam int ST_CY = 3;
  localparam int ST_OV = 2;
  localparam int ST_S = 1;
  localparam int ST_Z = 0;
  localparam logic [ST_W-1:0] STATUS_RST = 8'h20;
  localparam logic [XLEN-1:0] PC_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] PC_MASK = 32'h03FF_FFFE;
  localparam logic [XLEN-1:0] RA_MASK = 32'h03FF_FFFF;
endpackage

//--- rtl/crs_gpr_file.sv
`timescale 1ns/1ns
`default_nettype none
module crs_gpr_file #(
  parameter int N = crs_pkg::GPR_N
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [crs_pkg::GPR_AW-1:0] rd_a_addr,
  output logic [crs_pkg::XLEN-1:0] rd_a_data,
  input wire logic [crs_pkg::GPR_AW-1:0] rd_b_addr,
  output logic [crs_pkg::XLEN-1:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [crs_pkg::GPR_AW-1:0] wr_addr,
  input wire logic [crs_pkg::XLEN-1:0] wr_data,
  output logic [crs_pkg::XLEN-1:0] elem_ptr
);
  import crs_pkg::*;
  initial begin
    if (N != GPR_N) $error("crs_gpr_file: exactly 32 registers supported");
  end
  typedef struct packed {
    logic [N-1:1][XLEN-1:0] r;
  } crs_gpr_s;
  crs_gpr_s s_q, s_d;

  function automatic logic [XLEN-1:0] rd(input crs_gpr_s s,
                                         input logic [GPR_AW-1:0] a);
    rd = (a == GPR_ZERO) ? '0 : s.r[a];
  endfunction

  always_comb begin
    s_d = s_q;
    if (wr_en && wr_addr != GPR_ZERO) begin
      s_d.r[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_a_data = rd(s_q, rd_a_addr);
  assign rd_b_data = rd(s_q, rd_b_addr);
  assign elem_ptr = s_q.r[GPR_ELEM_PTR];
endmodule
`default_nettype wire

//--- rtl/crs_pc.sv
`timescale 1ns/1ns
`default_nettype none
module crs_pc (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [crs_pkg::XLEN-1:0] target,
  input wire logic advance,
  input wire logic [crs_pkg::STEP_W-1:0] step,
  output logic [crs_pkg::XLEN-1:0] pc
);
  import crs_pkg::*;
  typedef struct packed {
    logic [PC_W-1:0] pc;
  } crs_pc_s;
  crs_pc_s s_q, s_d;
  logic [PC_W-1:0] sum;

  always_comb begin
    s_d = s_q;
    // carry out of the top kept bit simply falls off
    sum = s_q.pc + PC_W'(step);
    if (load) begin
      s_d.pc = target[PC_W-1:0];
    end else if (advance) begin
      s_d.pc = sum;
    end
    s_d.pc[0] = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{pc: PC_RST[PC_W-1:0]};
    end else begin
      s_q <= s_d;
    end
  end

  assign pc = {{(XLEN-PC_W){1'b0}}, s_q.pc};
endmodule
`default_nettype wire

//--- sim/crs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module crs_core_model (
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic irq_accept_ok,
  input wire logic nmi_accept_ok,
  output logic ev_irq,
  output logic ev_nmi
);
  // a request the block cannot take is dropped, never held over
  assign ev_irq = irq_req & irq_accept_ok;
  assign ev_nmi = nmi_req & nmi_accept_ok;
endmodule
`default_nettype wire

//--- sim/crs_register_set_properties.sv
`timescale 1ns/1ns
`default_nettype none
module crs_rs_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [crs_pkg::GPR_AW-1:0] gpr_rd_a_addr,
  input wire logic [crs_pkg::XLEN-1:0] gpr_rd_a_data,
  input wire logic pc_branch,
  input wire logic pc_advance,
  input wire logic [crs_pkg::STEP_W-1:0] instr_len,
  input wire logic [crs_pkg::XLEN-1:0] pc,
  input wire logic sysreg_write_instr,
  input wire logic sysreg_read_instr,
  input wire logic [crs_pkg::SR_AW-1:0] sysreg_num,
  input wire logic [crs_pkg::XLEN-1:0] sysreg_wdata,
  input wire logic [crs_pkg::XLEN-1:0] sysreg_rdata,
  input wire logic flags_we,
  input wire logic [crs_pkg::XLEN-1:0] alu_result,
  input wire logic sat_event,
  input wire logic ev_sw_exception,
  input wire logic ev_irq,
  input wire logic ev_nmi,
  input wire logic ev_trap,
  input wire logic table_call_instr,
  input wire logic interrupt_return_instr,
  input wire logic table_call_return,
  input wire logic trap_return,
  input wire logic irq_accept_ok,
  input wire logic nmi_accept_ok,
  input wire logic [crs_pkg::ST_W-1:0] cpu_status_word
);
  import crs_pkg::*;
  // events and returns rewrite pc and status, so relations hold only without
  wire logic quiet = !(ev_sw_exception | ev_irq | ev_nmi | ev_trap |
    table_call_instr | interrupt_return_instr | table_call_return |
    trap_return);
  wire logic st_wr = sysreg_write_instr && sysreg_num == SR_STATUS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_zero_reg;
    gpr_rd_a_addr == GPR_ZERO |-> gpr_rd_a_data == 32'h0;
  endproperty
  a_zero_reg: assert property (p_zero_reg)
    else $error("register zero read nonzero");
  property p_pc_fix;
    pc[0] == 1'b0 && pc[31:26] == 6'h0;
  endproperty
  a_pc_fix: assert property (p_pc_fix)
    else $error("pc fixed bits not zero");
  property p_pc_adv;
    pc_advance && !pc_branch && quiet |=>
      pc == (($past(pc) + $past(instr_len)) & 32'h03FF_FFFE);
  endproperty
  a_pc_adv: assert property (p_pc_adv)
    else $error("pc advance wrong");
  property p_irq_id;
    cpu_status_word[ST_IRQ_BLOCK] |-> !irq_accept_ok;
  endproperty
  a_irq_id: assert property (p_irq_id)
    else $error("irq accepted while blocked");
  property p_irq_wr;
    st_wr && sysreg_wdata[ST_IRQ_BLOCK] |-> !irq_accept_ok;
  endproperty
  a_irq_wr: assert property (p_irq_wr)
    else $error("irq accepted during blocking write");
  property p_nmi_np;
    ev_nmi |=> cpu_status_word[7] && cpu_status_word[5] && !nmi_accept_ok;
  endproperty
  a_nmi_np: assert property (p_nmi_np)
    else $error("nmi flags not set");
  property p_exc_ep;
    ev_sw_exception && !ev_nmi |=> cpu_status_word[ST_EXC_ACTIVE];
  endproperty
  a_exc_ep: assert property (p_exc_ep)
    else $error("exception flag not set");
  property p_sat;
    cpu_status_word[ST_SAT] && !st_wr && !interrupt_return_instr &&
      !table_call_return && !trap_return |=> cpu_status_word[ST_SAT];
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation flag lost");
  property p_flags;
    flags_we && quiet && !sysreg_write_instr |=> cpu_status_word[1:0] ==
      {$past(alu_result[31]), $past(alu_result) == 32'h0};
  endproperty
  a_flags: assert property (p_flags)
    else $error("sign or zero flag wrong");
  property p_rd_status;
    sysreg_read_instr && sysreg_num == SR_STATUS && quiet &&
      !sysreg_write_instr |=> sysreg_rdata == {24'h0, $past(cpu_status_word)};
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read wrong");
  c_nmi: cover property (ev_nmi);
  c_sat: cover property (sat_event ##1 flags_we);
  c_idwr: cover property (st_wr && sysreg_wdata[ST_IRQ_BLOCK]);
endmodule
bind crs_register_set crs_rs_props chk_u (.*);
`default_nettype wire

//--- sim/tb_cpu_register_set.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_register_set;
  import crs_pkg::*;
  logic clk, sys_rst, gpr_wr_en, pc_branch, pc_advance, sysreg_write_instr;
  logic sysreg_read_instr, flags_we, alu_carry, alu_overflow, sat_event;
  logic ev_sw_exception, ev_irq, ev_nmi, ev_trap, table_call_instr;
  logic interrupt_return_instr, table_call_return, trap_return;
  logic irq_accept_ok, nmi_accept_ok, debug_mode, irq_req, nmi_req;
  logic [4:0] gpr_rd_a_addr, gpr_rd_b_addr, gpr_wr_addr, sysreg_num;
  logic [2:0] instr_len;
  logic [7:0] cpu_status_word;
  logic [31:0] gpr_rd_a_data, gpr_rd_b_data, gpr_wr_data, short_mem_base;
  logic [31:0] pc_branch_target, pc, sysreg_wdata, sysreg_rdata, alu_result;
  logic [31:0] ev_cause, ev_vector, seed, q, gm [32];
  int n_fail, n_tests;
  crs_register_set dut_u (.*);
  crs_core_model core_u (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_sr(input logic [4:0] n,
                                         input logic [31:0] v);
    case (n)
      SR_IRQ_RA, SR_NMI_RA, SR_TC_RA, SR_TR_RA: return v & 32'h03FF_FFFF;
      SR_IRQ_ST, SR_NMI_ST, SR_TC_ST, SR_TR_ST: return v & 32'h0000_00FF;
      SR_TC_BASE: return v & 32'h03FF_FFFE;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle after each access keeps strobes from toggling in a step
  task automatic sr(input logic wr, input logic [4:0] n, input logic [31:0] d);
    sysreg_write_instr = wr;
    sysreg_read_instr = !wr;
    sysreg_num = n;
    sysreg_wdata = d;
    @(negedge clk);
    sysreg_write_instr = 1'b0;
    sysreg_read_instr = 1'b0;
    q = sysreg_rdata;
    @(negedge clk);
  endtask
  task automatic fire(input int k, input logic [2:0] len);
    seed = lfsr(seed);
    instr_len = len;
    ev_cause = seed;
    ev_vector = 32'h0000_1001;
    {nmi_req, ev_sw_exception, irq_req} = 3'h1 << k;
    @(negedge clk);
    {nmi_req, ev_sw_exception, irq_req} = 3'h0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    {gpr_wr_en, pc_branch, pc_advance, sysreg_write_instr, sysreg_read_instr,
     flags_we, alu_carry, alu_overflow, sat_event, ev_sw_exception, ev_trap,
     table_call_instr, interrupt_return_instr, table_call_return, trap_return,
     irq_req, nmi_req} = '0;
    {gpr_rd_a_addr, gpr_rd_b_addr, gpr_wr_addr, sysreg_num, instr_len} = '0;
    {gpr_wr_data, pc_branch_target, sysreg_wdata, alu_result} = '0;
    {ev_cause, ev_vector} = '0;
    sys_rst = 1'b1;
    seed = 32'h5140E0D4;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    chk(cpu_status_word, 8'h20);
    chk(nmi_accept_ok, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      gpr_wr_en = 1'b1;
      gpr_wr_addr = i[4:0];
      gpr_wr_data = seed;
      gm[i] = (i == 0) ? 32'h0 : seed;
      @(negedge clk);
    end
    gpr_wr_en = 1'b0;
    for (int i = 0; i < 32; i++) begin
      gpr_rd_a_addr = i[4:0];
      gpr_rd_b_addr = 5'h1F - i[4:0];
      #10;
      chk(gpr_rd_a_data, gm[i]);
      chk(gpr_rd_b_data, gm[31-i]);
    end
    chk(short_mem_base, gm[30]);
    pc_branch_target = 32'hFFFF_FFFF;
    pc_branch = 1'b1;
    @(negedge clk);
    pc_branch = 1'b0;
    chk(pc, 32'h03FF_FFFE);
    instr_len = 3'h4;
    pc_advance = 1'b1;
    @(negedge clk);
    pc_advance = 1'b0;
    chk(pc, 32'h0000_0002);
    $display("test gpr and pc done");
    for (int i = 0; i < 32; i++) begin
      if (i == 5 || (i > 5 && i < 16) || i > 21) continue;
      seed = lfsr(seed);
      sr(1'b1, i[4:0], seed);
      sr(1'b0, i[4:0], 32'h0);
      chk(q, exp_sr(i[4:0], seed));
    end
    sr(1'b1, SR_STATUS, 32'hFFFF_FF1F);
    sr(1'b0, SR_STATUS, 32'h0);
    chk(q, 32'h0000_001F);
    chk(irq_accept_ok, 1'b1);
    sysreg_wdata = 32'h0000_0020;
    sysreg_write_instr = 1'b1;
    #10;
    chk(irq_accept_ok, 1'b0);
    @(negedge clk);
    sysreg_write_instr = 1'b0;
    chk(cpu_status_word, 8'h20);
    sr(1'b1, SR_STATUS, 32'h0);
    seed = lfsr(seed);
    alu_result = seed | 32'h8000_0000;
    flags_we = 1'b1;
    sat_event = 1'b1;
    @(negedge clk);
    chk(cpu_status_word, 8'h12);
    sat_event = 1'b0;
    alu_carry = 1'b1;
    alu_result = 32'h0;
    @(negedge clk);
    flags_we = 1'b0;
    alu_carry = 1'b0;
    chk(cpu_status_word, 8'h19);
    $display("test system registers done");
    pc_branch_target = 32'h0012_3450;
    pc_branch = 1'b1;
    @(negedge clk);
    pc_branch = 1'b0;
    fire(0, 3'h2);
    chk(pc, 32'h0000_1000);
    chk(irq_accept_ok, 1'b0);
    sr(1'b0, SR_IRQ_RA, 32'h0);
    chk(q, 32'h0012_3452);
    sr(1'b0, SR_IRQ_ST, 32'h0);
    chk(q, 32'h0000_0019);
    sr(1'b0, SR_CAUSE, 32'h0);
    chk(q, ev_cause);
    fire(0, 3'h2);
    sr(1'b0, SR_IRQ_RA, 32'h0);
    chk(q, 32'h0012_3452);
    fire(1, 3'h4);
    chk(cpu_status_word, 8'h79);
    sr(1'b0, SR_IRQ_RA, 32'h0);
    chk(q, 32'h0000_1004);
    sr(1'b0, SR_IRQ_ST, 32'h0);
    chk(q, 32'h0000_0039);
    fire(2, 3'h2);
    chk(cpu_status_word, 8'hF9);
    chk(nmi_accept_ok, 1'b0);
    sr(1'b0, SR_NMI_RA, 32'h0);
    chk(q, 32'h0000_1002);
    sr(1'b0, SR_NMI_ST, 32'h0);
    chk(q, 32'h0000_0079);
    sr(1'b1, SR_NMI_RA, 32'h0000_2223);
    interrupt_return_instr = 1'b1;
    @(negedge clk);
    interrupt_return_instr = 1'b0;
    chk(pc, 32'h0000_2222);
    chk(cpu_status_word, 8'h79);
    ev_trap = 1'b1;
    @(negedge clk);
    ev_trap = 1'b0;
    chk(debug_mode, 1'b1);
    chk(cpu_status_word, 8'hF9);
    trap_return = 1'b1;
    @(negedge clk);
    trap_return = 1'b0;
    chk(debug_mode, 1'b0);
    chk(pc, 32'h0000_2224);
    table_call_instr = 1'b1;
    @(negedge clk);
    table_call_instr = 1'b0;
    chk(pc, 32'h0000_1000);
    table_call_return = 1'b1;
    @(negedge clk);
    table_call_return = 1'b0;
    chk(pc, 32'h0000_2226);
    $display("test events done");
    close_out();
  end
endmodule
`default_nettype wire
